/* drcc_params.svh */
`ifndef DRCC_PARAMS_SVH
`define DRCC_PARAMS_SVH
// n-codes of the instruction set
`define DRCC_N_CONTROL 3'h4
`define DRCC_N_STATUS 3'h2
`define DRCC_N_DIAG 3'h5
`define DRCC_N_DAR 3'h1
`define DRCC_N_LEN 3'h6
`define DRCC_N_SELECT 3'h3
`define DRCC_N_INTCTL 3'h7
// control codes with n-code control
`define DRCC_FEED_START 8'h01
`define DRCC_FEED_STOP 8'h02
`define DRCC_READ 8'h04
`define DRCC_CLEAR_FLAGS 8'h80
// control byte 2 bits
`define DRCC_HOLD_BIT 0
`define DRCC_BPOCKET_BIT 2
// interrupt control byte bits
`define DRCC_INT_EN_BIT 0
`define DRCC_INT_CLR_BIT 1
// stacker codes
`define DRCC_POCKET_B 4'he
`define DRCC_POCKET_REJECT 4'hf
// status byte bits
`define DRCC_ST_END 1
`define DRCC_ST_IRQ 2
`define DRCC_ST_ATTN 3
`define DRCC_ST_PAR 4
`define DRCC_ST_NOOP 5
`define DRCC_ST_OVF 6
`define DRCC_ST_READY 7
// length counter
`define DRCC_LEN_LAST 9'h0ff
// timing
`define DRCC_CLK_PS 5000
`define DRCC_SELECT_WINDOW_MS 24
// cycles per ms and per us first, so no product passes 32 bits;
// the clock period must divide one microsecond evenly
`define DRCC_SELECT_CYCLES (`DRCC_SELECT_WINDOW_MS * (1000000000 / `DRCC_CLK_PS))
`define DRCC_DOC_GAP_US 9500
`define DRCC_GAP_CYCLES (`DRCC_DOC_GAP_US * (1000000 / `DRCC_CLK_PS))
`endif

/* drcc_pkg.sv */
package drcc_pkg;
  // instruction class from the processor
  typedef enum logic [1:0] {drcc_none, drcc_start, drcc_load, drcc_sense} drcc_kind_type;
  // one processor i/o instruction
  typedef struct packed {
    drcc_kind_type kind;
    logic [2:0] n_code;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] data;
  } drcc_cmd_type;
  // one character from the reader
  typedef struct packed {
    logic [7:0] code;
    logic parity;
  } drcc_char_type;
  // one cycle-steal store
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } drcc_store_type;
  // read transfer states
  typedef enum logic [1:0] {drcc_idle, drcc_armed, drcc_read} drcc_xfer_type;
endpackage : drcc_pkg

/* drcc_rdr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drcc_rdr_model
  import drcc_pkg::*;
#(
  parameter int GAP = 2
) (
  input wire logic clock,
  input wire logic feed_enable,
  output logic doc_separated,
  output logic doc_at_head,
  output logic doc_left_head,
  output logic doc_end,
  output logic char_valid,
  output drcc_char_type char_in
);
  // documents waiting in the hopper
  int hopper = 0;
  // documents separated so far
  int sep_count = 0;
  // cycles before the separator may act again
  int gap = 0;
  initial begin
    doc_separated = 1'b0;
    doc_at_head = 1'b0;
    doc_left_head = 1'b0;
    doc_end = 1'b0;
    char_valid = 1'b0;
    char_in = '0;
  end
  // separator: only while the adapter enables feeding
  // spaced separations
  always @(negedge clock) begin
    doc_separated <= 1'b0;
    if (gap > 0) begin
      gap <= gap - 1;
    end else if (feed_enable && hopper > 0) begin
      doc_separated <= 1'b1;
      hopper <= hopper - 1;
      sep_count <= sep_count + 1;
      gap <= GAP;
    end
  end
  // document arrives at the read head
  task automatic at_head();
    @(negedge clock);
    doc_at_head = 1'b1;
    @(negedge clock);
    doc_at_head = 1'b0;
  endtask : at_head
  // document leaves the read head
  task automatic leave_head();
    @(negedge clock);
    doc_left_head = 1'b1;
    @(negedge clock);
    doc_left_head = 1'b0;
  endtask : leave_head
  // n characters back to back, then document end
  // odd parity unless bad asked
  task automatic send_doc(input int n, input logic bad);
    at_head();
    char_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      char_in = '{code: 8'h30 + 8'(i), parity: ~^(8'h30 + 8'(i)) ^ bad};
      @(negedge clock);
    end
    char_valid = 1'b0;
    // released line shows no stale value
    char_in = ~char_in;
    doc_end = 1'b1;
    @(negedge clock);
    doc_end = 1'b0;
  endtask : send_doc
endmodule : drcc_rdr_model
`default_nettype wire

/* drcc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb
  import drcc_pkg::*;
;
  logic clock, reset, cmd_valid, thirteen_pocket, rdr_online, rdr_ready, cpu_stopped;
  logic stop_delay_timeout, left_jam, right_jam, treadle_release, svc_request, io_disconnect;
  logic doc_separated, doc_at_head, doc_left_head, doc_end, char_valid;
  logic feed_enable_reg, irq_reg, sense_valid_reg, store_valid_reg, stacker_valid_reg;
  logic reject_doc_reg, pocket_hold_reg, svc_resp_reg;
  logic [7:0] sense_data_reg;
  logic [3:0] stacker_code_reg;
  drcc_cmd_type cmd;
  drcc_char_type char_in;
  drcc_store_type store_reg;
  // captured stores and pulse counts
  drcc_store_type stores[$];
  int err_count = 0;
  int cmp_count = 0;
  int rej_count = 0;
  int stk_count = 0;
  int rsp_count = 0;
  // short counts keep the run brief
  drcc_top #(.SEL_CYCLES(50), .GAP_CYCLES(20)) dut (.clock(clock), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .thirteen_pocket(thirteen_pocket),
    .rdr_online(rdr_online), .rdr_ready(rdr_ready), .cpu_stopped(cpu_stopped),
    .doc_separated(doc_separated), .doc_at_head(doc_at_head),
    .doc_left_head(doc_left_head), .doc_end(doc_end), .char_valid(char_valid),
    .char_in(char_in), .stop_delay_timeout(stop_delay_timeout), .left_jam(left_jam),
    .right_jam(right_jam), .treadle_release(treadle_release), .svc_request(svc_request),
    .io_disconnect(io_disconnect), .feed_enable_reg(feed_enable_reg), .irq_reg(irq_reg),
    .sense_valid_reg(sense_valid_reg), .sense_data_reg(sense_data_reg),
    .store_valid_reg(store_valid_reg), .store_reg(store_reg),
    .stacker_valid_reg(stacker_valid_reg), .stacker_code_reg(stacker_code_reg),
    .reject_doc_reg(reject_doc_reg), .pocket_hold_reg(pocket_hold_reg),
    .svc_resp_reg(svc_resp_reg));
  drcc_rdr_model model (.clock(clock), .feed_enable(feed_enable_reg),
    .doc_separated(doc_separated), .doc_at_head(doc_at_head),
    .doc_left_head(doc_left_head), .doc_end(doc_end), .char_valid(char_valid),
    .char_in(char_in));
  // free-running clock, 5 ns
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // one-cycle outputs sampled mid-cycle, once each
  always @(negedge clock) begin
    if (store_valid_reg === 1'b1) stores.push_back(store_reg);
    if (reject_doc_reg === 1'b1) rej_count++;
    if (stacker_valid_reg === 1'b1) stk_count++;
    if (svc_resp_reg === 1'b1) rsp_count++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // one instruction, held for exactly one taking edge
  task automatic io(input drcc_kind_type k, input logic [2:0] n, input logic [7:0] c1,
    input logic [7:0] c2, input logic [15:0] d);
    @(negedge clock);
    cmd = '{k, n, c1, c2, d};
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : io
  // sense answer stands for the one cycle after the taking edge
  task automatic sense(input logic [2:0] n, input logic [7:0] e);
    io(drcc_sense, n, 8'h00, 8'h00, 16'h0000);
    `CHK(sense_valid_reg, 1'b1);
    `CHK(sense_data_reg, e);
  endtask : sense
  // bounded wait for a stacker pulse
  task automatic wait_stk(input int want);
    for (int i = 0; i < 200 && stk_count < want; i++) @(negedge clock);
    if (stk_count < want) begin
      err_count++;
      stop_test();
    end
  endtask : wait_stk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    {cmd_valid, thirteen_pocket, cpu_stopped, stop_delay_timeout} = 4'h0;
    {left_jam, right_jam, treadle_release, svc_request, io_disconnect} = 5'h00;
    cmd = '0;
    rdr_online = 1'b1;
    rdr_ready = 1'b1;
    reset = 1'b1;
    cyc(4);
    reset = 1'b0;
    sense(3'h2, 8'h80);
    svc_request = 1'b1;
    io_disconnect = 1'b1;
    sense(3'h5, 8'h12);
    {svc_request, io_disconnect} = 2'b00;
    sense(3'h0, 8'h00);
    io(drcc_start, 3'h4, 8'h01, 8'h00, 16'h0000);
    cyc(2);
    `CHK(feed_enable_reg, 1'b1);
    cpu_stopped = 1'b1;
    cyc(3);
    `CHK(feed_enable_reg, 1'b0);
    cpu_stopped = 1'b0;
    // another instruction first, so the stop is not single-document
    sense(3'h2, 8'h80);
    io(drcc_start, 3'h4, 8'h02, 8'h00, 16'h0000);
    cyc(2);
    `CHK(feed_enable_reg, 1'b0);
    rdr_ready = 1'b0;
    io(drcc_start, 3'h4, 8'h01, 8'h00, 16'h0000);
    cyc(3);
    `CHK(feed_enable_reg, 1'b0);
    rdr_ready = 1'b1;
    cyc(3);
    `CHK(feed_enable_reg, 1'b1);
    sense(3'h2, 8'h80);
    rdr_ready = 1'b0;
    io(drcc_start, 3'h4, 8'h02, 8'h00, 16'h0000);
    rdr_ready = 1'b1;
    cyc(3);
    `CHK(feed_enable_reg, 1'b0);
    model.hopper = 5;
    rdr_ready = 1'b0;
    io(drcc_start, 3'h4, 8'h01, 8'h00, 16'h0000);
    io(drcc_start, 3'h4, 8'h02, 8'h00, 16'h0000);
    rdr_ready = 1'b1;
    cyc(40);
    `CHK(model.sep_count, 1);
    `CHK(feed_enable_reg, 1'b0);
    model.hopper = 0;
    io(drcc_load, 3'h1, 8'h00, 8'h00, 16'h1000);
    io(drcc_load, 3'h6, 8'h00, 8'h00, 16'h00fe);
    io(drcc_start, 3'h7, 8'h01, 8'h00, 16'h0000);
    io(drcc_start, 3'h4, 8'h04, 8'h00, 16'h0000);
    model.send_doc(3, 1'b0);
    cyc(3);
    `CHK(stores.size(), 2);
    `CHK(stores[0], {16'h1000, 8'h30});
    `CHK(stores[1], {16'h0fff, 8'h31});
    `CHK(rsp_count, 2);
    `CHK(irq_reg, 1'b1);
    sense(3'h2, 8'hc6);
    io(drcc_start, 3'h7, 8'h03, 8'h00, 16'h0000);
    cyc(2);
    `CHK(irq_reg, 1'b0);
    model.at_head();
    cyc(2);
    `CHK(rej_count, 1);
    model.leave_head();
    wait_stk(1);
    `CHK(stacker_code_reg, 4'hf);
    `CHK(rej_count, 2);
    io(drcc_start, 3'h4, 8'h80, 8'h00, 16'h0000);
    model.leave_head();
    io(drcc_start, 3'h3, 8'h05, 8'h00, 16'h0000);
    cyc(60);
    `CHK(stk_count, 2);
    `CHK(stacker_code_reg, 4'h5);
    // hold and B pocket in one start
    thirteen_pocket = 1'b1;
    io(drcc_start, 3'h4, 8'h01, 8'h05, 16'h0000);
    cyc(2);
    `CHK(pocket_hold_reg, 1'b1);
    `CHK(stacker_code_reg, 4'he);
    `CHK(feed_enable_reg, 1'b0);
    treadle_release = 1'b1;
    cyc(1);
    treadle_release = 1'b0;
    cyc(3);
    `CHK(pocket_hold_reg, 1'b0);
    `CHK(feed_enable_reg, 1'b1);
    for (int j = 0; j < 3; j++) begin
      io(drcc_start, 3'h4, 8'h80, 8'h00, 16'h0000);
      {right_jam, left_jam, stop_delay_timeout} = 3'b001 << j;
      cyc(1);
      {right_jam, left_jam, stop_delay_timeout} = 3'b000;
      sense(3'h2, 8'hca);
    end
    io(drcc_start, 3'h4, 8'h80, 8'h00, 16'h0000);
    io(drcc_load, 3'h6, 8'h00, 8'h00, 16'h00ff);
    io(drcc_start, 3'h4, 8'h04, 8'h00, 16'h0000);
    model.send_doc(1, 1'b1);
    cyc(3);
    sense(3'h2, 8'hd6);
    // separator held off after a document
    model.hopper = 2;
    for (int i = 0; i < 50 && model.sep_count < 2; i++) @(negedge clock);
    `CHK(model.sep_count, 2);
    cyc(10);
    `CHK(feed_enable_reg, 1'b0);
    cyc(30);
    `CHK(model.sep_count, 3);
    io(drcc_start, 3'h4, 8'h00, 8'h01, 16'h0000);
    io(drcc_start, 3'h3, 8'h0f, 8'h00, 16'h0000);
    cyc(1);
    `CHK(pocket_hold_reg, 1'b1);
    `CHK(stacker_code_reg, 4'hf);
    // hold set again before a pocket select
    io(drcc_start, 3'h4, 8'h00, 8'h01, 16'h0000);
    io(drcc_start, 3'h3, 8'h07, 8'h00, 16'h0000);
    cyc(1);
    `CHK(stacker_code_reg, 4'h7);
    `CHK(feed_enable_reg, 1'b0);
    stop_test();
  end
endmodule : tb
`default_nettype wire

/* drcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drcc_params.svh"
module drcc_top
  import drcc_pkg::*;
#(
  parameter int SEL_CYCLES = `DRCC_SELECT_CYCLES,
  parameter int GAP_CYCLES = `DRCC_GAP_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire drcc_cmd_type cmd,
  input wire logic thirteen_pocket,
  input wire logic rdr_online,
  input wire logic rdr_ready,
  input wire logic cpu_stopped,
  input wire logic doc_separated,
  input wire logic doc_at_head,
  input wire logic doc_left_head,
  input wire logic doc_end,
  input wire logic char_valid,
  input wire drcc_char_type char_in,
  input wire logic stop_delay_timeout,
  input wire logic left_jam,
  input wire logic right_jam,
  input wire logic treadle_release,
  input wire logic svc_request,
  input wire logic io_disconnect,
  output logic feed_enable_reg,
  output logic irq_reg,
  output logic sense_valid_reg,
  output logic [7:0] sense_data_reg,
  output logic store_valid_reg,
  output drcc_store_type store_reg,
  output logic stacker_valid_reg,
  output logic [3:0] stacker_code_reg,
  output logic reject_doc_reg,
  output logic pocket_hold_reg,
  output logic svc_resp_reg
);

  // odd parity over code and parity bit
  function automatic logic odd_ok(input drcc_char_type c);
    odd_ok = ^{c.code, c.parity};
  endfunction : odd_ok

  // state
  drcc_xfer_type xfer_reg; // read transfer state
  logic [15:0] dar_reg; // data address register
  logic [8:0] len_reg; // length counter, bit 8 = overflow
  logic run_reg; // feed requested by program
  logic one_doc_reg; // single document pending
  logic last_start_reg; // previous instruction was feed start
  logic fed_since_start_reg; // a document separated since the last start
  logic [31:0] gap_cnt_reg; // inter-document gap timer
  logic [31:0] sel_cnt_reg; // stacker select window timer
  logic sel_wait_reg; // select window open
  logic int_en_reg; // interrupt enable
  logic irq_latch_reg; // interrupt request latch
  logic end_req_reg; // end request
  logic reject_flag_reg; // auto-select flag
  logic sort_check_reg; // sort check
  logic stopped_reg; // sorter stopped
  logic attention_reg; // attention
  logic parity_err_reg; // data parity check
  logic noop_reg; // unrecognised start

  // instruction decode
  logic is_start, is_ctrl, feed_start_cmd, feed_stop_cmd, read_cmd, clear_cmd;
  logic select_cmd, intctl_cmd, load_cmd, sense_cmd, known_start;
  assign is_start = cmd_valid && (cmd.kind == drcc_start);
  assign is_ctrl = is_start && (cmd.n_code == `DRCC_N_CONTROL);
  assign feed_start_cmd = is_ctrl && (cmd.ctrl1 == `DRCC_FEED_START);
  assign feed_stop_cmd = is_ctrl && (cmd.ctrl1 == `DRCC_FEED_STOP);
  assign read_cmd = is_ctrl && (cmd.ctrl1 == `DRCC_READ);
  assign clear_cmd = is_ctrl && (cmd.ctrl1 == `DRCC_CLEAR_FLAGS);
  assign select_cmd = is_start && (cmd.n_code == `DRCC_N_SELECT);
  assign intctl_cmd = is_start && (cmd.n_code == `DRCC_N_INTCTL);
  assign load_cmd = cmd_valid && (cmd.kind == drcc_load);
  assign sense_cmd = cmd_valid && (cmd.kind == drcc_sense);
  assign known_start = is_ctrl || select_cmd || intctl_cmd;

  // character accept and transfer end
  logic accept, xfer_done, sel_timeout, gap_busy, feed_ok;
  assign accept = (xfer_reg == drcc_read) && char_valid && !len_reg[8];
  assign xfer_done = (xfer_reg == drcc_read) &&
                     (doc_end || len_reg[8] || (accept && len_reg == `DRCC_LEN_LAST));
  assign sel_timeout = sel_wait_reg && (sel_cnt_reg == 32'h0) && !select_cmd;
  assign gap_busy = (gap_cnt_reg != 32'h0);
  // every stop condition gates the separator except jams and stop delay timeout
  assign feed_ok = run_reg && rdr_online && rdr_ready && !cpu_stopped &&
                   !pocket_hold_reg && !stopped_reg && !gap_busy && !doc_separated;

  // live sense bytes
  logic [7:0] status_byte, diag_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[`DRCC_ST_END] = end_req_reg;
    status_byte[`DRCC_ST_IRQ] = irq_latch_reg && int_en_reg;
    status_byte[`DRCC_ST_ATTN] = attention_reg;
    status_byte[`DRCC_ST_PAR] = parity_err_reg;
    status_byte[`DRCC_ST_NOOP] = noop_reg;
    status_byte[`DRCC_ST_OVF] = len_reg[8];
    status_byte[`DRCC_ST_READY] = rdr_online && rdr_ready;
  end
  // diagnostic byte; the reader never writes, so write call is zero
  assign diag_byte = {xfer_reg != drcc_idle, xfer_reg == drcc_read, 1'b0, io_disconnect,
                      int_en_reg, svc_resp_reg, svc_request, irq_latch_reg};

  // feed request latch and single-document mode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      run_reg <= 1'b0;
      one_doc_reg <= 1'b0;
      last_start_reg <= 1'b0;
      fed_since_start_reg <= 1'b0;
    end else begin
      // the single document may already be out before the stop lands
      if (feed_start_cmd) begin
        fed_since_start_reg <= 1'b0;
      end else if (doc_separated) begin
        fed_since_start_reg <= 1'b1;
      end
      // start is held until reader is ready
      if (feed_start_cmd) begin
        run_reg <= 1'b1;
        one_doc_reg <= 1'b0;
      end else if (feed_stop_cmd) begin
        // stop right after start: one document, unless already fed
        if (last_start_reg && !fed_since_start_reg && !doc_separated) begin
          one_doc_reg <= 1'b1;
        end else begin
          // plain stop clears request, ready or not
          run_reg <= 1'b0;
          one_doc_reg <= 1'b0;
        end
      end else if (doc_separated && one_doc_reg) begin
        run_reg <= 1'b0;
        one_doc_reg <= 1'b0;
      end
      // "immediately" means the very next instruction
      if (cmd_valid) begin
        last_start_reg <= feed_start_cmd;
      end
    end
  end

  // separator enable and document gap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      feed_enable_reg <= 1'b0;
      gap_cnt_reg <= 32'h0;
    end else begin
      feed_enable_reg <= feed_ok;
      if (doc_separated && thirteen_pocket) begin
        gap_cnt_reg <= GAP_CYCLES[31:0];
      end else if (gap_busy) begin
        gap_cnt_reg <= gap_cnt_reg - 32'h1;
      end
    end
  end

  // read transfer and cycle-steal stores
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      xfer_reg <= drcc_idle;
      dar_reg <= 16'h0000;
      len_reg <= 9'h000;
      store_valid_reg <= 1'b0;
      store_reg <= '0;
      svc_resp_reg <= 1'b0;
    end else begin
      store_valid_reg <= accept;
      svc_resp_reg <= accept;
      // loads only take effect outside the read state
      if (load_cmd && xfer_reg != drcc_read) begin
        if (cmd.n_code == `DRCC_N_DAR) begin
          dar_reg <= cmd.data;
        end else if (cmd.n_code == `DRCC_N_LEN) begin
          len_reg <= {1'b0, cmd.data[7:0]};
        end
      end
      if (accept) begin
        store_reg <= '{addr: dar_reg, data: char_in.code};
        dar_reg <= dar_reg - 16'h1;
        len_reg <= len_reg + 9'h1;
      end
      case (xfer_reg)
        drcc_idle: begin
          if (read_cmd) begin
            xfer_reg <= drcc_armed;
          end
        end
        drcc_armed: begin
          if (doc_at_head) begin
            xfer_reg <= drcc_read;
          end
        end
        drcc_read: begin
          if (xfer_done) begin
            xfer_reg <= drcc_idle;
          end
        end
        default: begin
          xfer_reg <= drcc_idle;
        end
      endcase
    end
  end

  // interrupt enable, request latch and end request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_en_reg <= 1'b0;
      irq_latch_reg <= 1'b0;
      end_req_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (intctl_cmd) begin
        int_en_reg <= cmd.ctrl1[`DRCC_INT_EN_BIT];
      end
      // set wins over a clear in the same cycle
      if (xfer_done) begin
        irq_latch_reg <= 1'b1;
      end else if (intctl_cmd && cmd.ctrl1[`DRCC_INT_CLR_BIT]) begin
        irq_latch_reg <= 1'b0;
      end
      if (xfer_done) begin
        end_req_reg <= 1'b1;
      end else if (read_cmd) begin
        end_req_reg <= 1'b0;
      end
      irq_reg <= irq_latch_reg && int_en_reg;
    end
  end

  // stacker select window
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_wait_reg <= 1'b0;
      sel_cnt_reg <= 32'h0;
    end else begin
      // window opens as document leaves head
      if (doc_left_head) begin
        sel_wait_reg <= 1'b1;
        sel_cnt_reg <= SEL_CYCLES[31:0] - 32'h1;
      end else if (select_cmd || sel_timeout) begin
        sel_wait_reg <= 1'b0;
      end else if (sel_wait_reg) begin
        sel_cnt_reg <= sel_cnt_reg - 32'h1;
      end
    end
  end

  // stacker output, reject pulse and pocket hold
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stacker_valid_reg <= 1'b0;
      stacker_code_reg <= 4'h0;
      reject_doc_reg <= 1'b0;
      pocket_hold_reg <= 1'b0;
    end else begin
      stacker_valid_reg <= 1'b0;
      reject_doc_reg <= sel_timeout || (doc_at_head && xfer_reg == drcc_idle);
      // timeout routes to the reject stacker
      if (sel_timeout) begin
        stacker_valid_reg <= 1'b1;
        stacker_code_reg <= `DRCC_POCKET_REJECT;
      end else if (select_cmd) begin
        stacker_valid_reg <= 1'b1;
        stacker_code_reg <= cmd.ctrl1[3:0];
      end else if (is_ctrl && thirteen_pocket && cmd.ctrl2[`DRCC_BPOCKET_BIT]) begin
        stacker_valid_reg <= 1'b1;
        stacker_code_reg <= `DRCC_POCKET_B;
      end
      if (is_ctrl && thirteen_pocket) begin
        pocket_hold_reg <= cmd.ctrl2[`DRCC_HOLD_BIT];
      end else if (treadle_release) begin
        pocket_hold_reg <= 1'b0;
      end
    end
  end

  // sticky flags; every set wins over the clear command
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reject_flag_reg <= 1'b0;
      sort_check_reg <= 1'b0;
      stopped_reg <= 1'b0;
      attention_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      noop_reg <= 1'b0;
    end else begin
      if (clear_cmd) begin
        reject_flag_reg <= 1'b0;
        sort_check_reg <= 1'b0;
        stopped_reg <= 1'b0;
        attention_reg <= 1'b0;
        parity_err_reg <= 1'b0;
        noop_reg <= 1'b0;
      end
      if (sel_timeout || (doc_at_head && xfer_reg == drcc_idle)) begin
        reject_flag_reg <= 1'b1;
      end
      if (sel_timeout) begin
        sort_check_reg <= 1'b1;
        stopped_reg <= 1'b1;
      end
      // attention on stop delay or jams, thirteen-pocket mode only
      if (thirteen_pocket && (stop_delay_timeout || left_jam || right_jam)) begin
        attention_reg <= 1'b1;
      end
      if (accept && thirteen_pocket && !odd_ok(char_in)) begin
        parity_err_reg <= 1'b1;
      end
      if (is_start && !known_start) begin
        noop_reg <= 1'b1;
      end
    end
  end

  // sense answer; reading alters no latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sense_valid_reg <= 1'b0;
      sense_data_reg <= 8'h00;
    end else begin
      sense_valid_reg <= sense_cmd;
      // capture live byte at sense time
      if (sense_cmd && cmd.n_code == `DRCC_N_STATUS) begin
        sense_data_reg <= status_byte;
      end else if (sense_cmd && cmd.n_code == `DRCC_N_DIAG) begin
        sense_data_reg <= diag_byte;
      end else if (sense_cmd) begin
        sense_data_reg <= 8'h00;
      end
    end
  end

  // helper for descending address check
  logic seen_store_reg;
  logic [15:0] last_addr_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      seen_store_reg <= 1'b0;
      last_addr_reg <= 16'h0000;
    end else if (xfer_reg == drcc_armed) begin
      // a new transfer forgets the last address
      seen_store_reg <= 1'b0;
    end else if (store_valid_reg) begin
      seen_store_reg <= 1'b1;
      last_addr_reg <= store_reg.addr;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_store_descends;
    store_valid_reg && seen_store_reg |->
      store_reg.addr == last_addr_reg - 16'h1;
  endproperty
  a_store_descends: assert property (p_store_descends) else $error("store address not descending");

  property p_len_blocks;
    xfer_reg == drcc_read && len_reg[8] |=> !store_valid_reg;
  endproperty
  a_len_blocks: assert property (p_len_blocks) else $error("store after count exhausted");

  property p_done_irq;
    xfer_done && int_en_reg && !intctl_cmd |=> irq_latch_reg ##1 irq_reg;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no interrupt after read end");

  property p_hold_no_feed;
    pocket_hold_reg |=> !feed_enable_reg;
  endproperty
  a_hold_no_feed: assert property (p_hold_no_feed) else $error("feeding while hold set");

  property p_cpu_stop;
    cpu_stopped |=> !feed_enable_reg;
  endproperty
  a_cpu_stop: assert property (p_cpu_stop) else $error("feeding while processor stopped");

  property p_late_read;
    doc_at_head && xfer_reg == drcc_idle |=> reject_doc_reg && reject_flag_reg;
  endproperty
  a_late_read: assert property (p_late_read) else $error("late read not rejected");

  property p_sort_timeout;
    sel_timeout |=> stopped_reg && sort_check_reg && stacker_valid_reg &&
      stacker_code_reg == `DRCC_POCKET_REJECT;
  endproperty
  a_sort_timeout: assert property (p_sort_timeout) else $error("sort check not handled");

  property p_stop_kills;
    feed_stop_cmd && !last_start_reg |=> !run_reg ##1 !feed_enable_reg;
  endproperty
  a_stop_kills: assert property (p_stop_kills) else $error("feed stop ignored");

  property p_single_doc;
    feed_stop_cmd && last_start_reg && !fed_since_start_reg && !doc_separated |=>
      run_reg && one_doc_reg;
  endproperty
  a_single_doc: assert property (p_single_doc) else $error("single document mode missed");

  property p_single_done;
    feed_stop_cmd && last_start_reg && (fed_since_start_reg || doc_separated) |=> !run_reg;
  endproperty
  a_single_done: assert property (p_single_done) else $error("second document fed");

  property p_parity;
    accept && thirteen_pocket && !odd_ok(char_in) |=> parity_err_reg;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not flagged");

  property p_sense_status;
    sense_cmd && cmd.n_code == `DRCC_N_STATUS |=>
      sense_valid_reg && sense_data_reg == $past(status_byte);
  endproperty
  a_sense_status: assert property (p_sense_status) else $error("status sense mismatch");

  property p_cov_read;
    xfer_reg == drcc_armed && doc_at_head ##[1:300] xfer_done;
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_timeout;
    sel_timeout;
  endproperty
  c_cov_timeout: cover property (p_cov_timeout);

  property p_cov_single;
    feed_stop_cmd && last_start_reg ##[1:300] doc_separated;
  endproperty
  c_cov_single: cover property (p_cov_single);

endmodule : drcc_top
`default_nettype wire
